// >>> src/qpc_consts.svh
`ifndef QPC_CONSTS_SVH
`define QPC_CONSTS_SVH

// ---------------------------------------------------------------------------
// Frame layout.
// ---------------------------------------------------------------------------

// Device type nibble of the first byte; the value is arbitrary.
`define QPC_DEV_TYPE        4'ha
`define QPC_ACK_BIT_IDX     4'h8

// ---------------------------------------------------------------------------
// Instruction nibbles.
// ---------------------------------------------------------------------------

`define QPC_OP_WR_WIPER     4'ha
`define QPC_OP_RD_SETTING   4'hb
`define QPC_OP_WR_SETTING   4'hc
`define QPC_OP_COPY_TO_WIP  4'hd
`define QPC_OP_SAVE_WIP     4'he
`define QPC_OP_STEP         4'h2
`define QPC_OP_GCOPY_TO_WIP 4'h1
`define QPC_OP_GSAVE_WIP    4'h8

// ---------------------------------------------------------------------------
// Reset values and limits.
// ---------------------------------------------------------------------------

`define QPC_WIPER_RESET     8'h00
`define QPC_SETTING_RESET   8'h00
`define QPC_WIPER_MAX       8'hff
`define QPC_WIPER_MIN       8'h00

// ---------------------------------------------------------------------------
// Timing.
// ---------------------------------------------------------------------------

`define QPC_CLK_PERIOD_NS   4
`define QPC_NV_WRITE_MS     10
`define QPC_NV_WRITE_CYCLES (`QPC_NV_WRITE_MS * 1_000_000 / `QPC_CLK_PERIOD_NS)
// Phases of one 16-cycle bus clock slot made by the host.
`define QPC_PH_SCL_LOW      4'h0
`define QPC_PH_SDA_SET      4'h4
`define QPC_PH_SCL_HIGH     4'h8
`define QPC_PH_STOP_REL     4'hc
`define QPC_PH_SAMPLE       4'he
`define QPC_PH_LAST         4'hf

`endif

// >>> src/qpc_pkg.sv
package qpc_pkg;

  // ---------------------------------------------------------------------------
  // Frame state of the device end.
  // ---------------------------------------------------------------------------

  typedef enum logic [3:0] {
    ds_idle,
    ds_devb,
    ds_instr,
    ds_wdata,
    ds_ack,
    ds_rdata,
    ds_rack,
    ds_step,
    ds_wait
  } qpc_dev_state_t;

  // ---------------------------------------------------------------------------
  // Sequencer state of the host end.
  // ---------------------------------------------------------------------------

  typedef enum logic [1:0] {
    hs_idle,
    hs_start,
    hs_bit,
    hs_stop
  } qpc_host_state_t;

endpackage

// >>> src/qpc_bus_if.sv
`timescale 1ns/1ps

interface qpc_bus_if;

  // Bus clock, driven only by the host.
  logic scl;
  // Open-drain data line: each end drives low while its enable is high.
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Pulled-up wire: any enabled driver that drives low pulls it low.
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );

  modport device (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

endinterface

// >>> src/qpc_device.sv
`timescale 1ns/1ps
`include "qpc_consts.svh"
// Functional notes
// - Wiper write loads data byte into wiper.
// - Setting read drives selected byte, MSB first.
// - Setting write acknowledges and stores data byte.
// - Copy setting register into its wiper.
// - Save wiper into setting, then write cycle.
// - Step instruction moves wiper per bit.
// - Global copy loads all wipers from bank.
// - Global save stores all wipers, write cycle.
// - Acknowledge device byte only on matching straps.
// - Data high steps up, low steps down.
// - Nonvolatile write cycle ends within ten milliseconds.
module qpc_device #(
  parameter int unsigned NV_WRITE_CYCLES = `QPC_NV_WRITE_CYCLES
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Two-wire bus.
  qpc_bus_if.device        bus,
  // Address strap pins.
  input  wire logic [3:0]  i_addr_strap,
  // Potentiometer state.
  output logic      [31:0] o_wiper_pos,
  output logic             o_nv_busy
);

  localparam int BUSY_W = $clog2(NV_WRITE_CYCLES + 1);

  // ---------------------------------------------------------------------------
  // Pin synchronisers and bus events.
  // ---------------------------------------------------------------------------

  logic [1:0]                scl_sy_q;
  logic [1:0]                sda_sy_q;
  logic                      scl_p_q;
  logic                      sda_p_q;
  logic [3:0]                strap_s1_q;
  logic [3:0]                strap_q;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_ev;
  logic                      stop_ev;
  logic                      sda_s;

  // Two flip-flops on every pin, then one more stage on the bus clock and data pins for edge detection.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sy_q   <= 2'h3;
      sda_sy_q   <= 2'h3;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
      strap_s1_q <= 4'h0;
      strap_q    <= 4'h0;
    end else begin
      scl_sy_q   <= {scl_sy_q[0], bus.scl};
      sda_sy_q   <= {sda_sy_q[0], bus.sda};
      scl_p_q    <= scl_sy_q[1];
      sda_p_q    <= sda_sy_q[1];
      strap_s1_q <= i_addr_strap;
      strap_q    <= strap_s1_q;
    end
  end

  // Start and stop are data edges while the bus clock stays high.
  assign sda_s    = sda_sy_q[1];
  assign scl_rise = scl_sy_q[1] & ~scl_p_q;
  assign scl_fall = ~scl_sy_q[1] & scl_p_q;
  assign start_ev = scl_sy_q[1] & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev  = scl_sy_q[1] & scl_p_q & ~sda_p_q & sda_s;

  // ---------------------------------------------------------------------------
  // Frame decoder.
  // ---------------------------------------------------------------------------

  qpc_pkg::qpc_dev_state_t   st_q;
  qpc_pkg::qpc_dev_state_t   nxt_q;
  qpc_pkg::qpc_dev_state_t   ack_next;
  logic [2:0]                cnt_q;
  logic [7:0]                sh_q;
  logic                      drv_q;
  logic                      sda_oe_q;
  logic                      sda_o_q;
  logic [3:0]                op_q;
  logic [1:0]                bank_q;
  logic [1:0]                pot_q;
  logic [7:0]                data_q;
  logic                      step_up_q;
  logic [7:0]                rx_byte;
  logic [7:0]                rd_byte;
  logic                      ack_take;
  logic                      busy_q;
  logic [7:0]                nv_sel_w [4];

  assign rx_byte = {sh_q[6:0], sda_s};
  assign rd_byte = nv_sel_w[pot_q];

  // Decides whether a completed byte is acknowledged and what follows it.
  always_comb begin
    ack_take = 1'b0;
    ack_next = qpc_pkg::ds_wait;
    unique case (st_q)
      qpc_pkg::ds_devb: begin
        ack_take = (rx_byte[7:4] == `QPC_DEV_TYPE) && (rx_byte[3:0] == strap_q) && !busy_q;
        ack_next = qpc_pkg::ds_instr;
      end
      qpc_pkg::ds_instr: begin
        unique case (rx_byte[7:4])
          `QPC_OP_WR_WIPER: begin
            ack_take = (rx_byte[3:2] == 2'h0);
            ack_next = qpc_pkg::ds_wdata;
          end
          `QPC_OP_STEP: begin
            ack_take = (rx_byte[3:2] == 2'h0);
            ack_next = qpc_pkg::ds_step;
          end
          `QPC_OP_RD_SETTING: begin
            ack_take = 1'b1;
            ack_next = qpc_pkg::ds_rdata;
          end
          `QPC_OP_WR_SETTING: begin
            ack_take = 1'b1;
            ack_next = qpc_pkg::ds_wdata;
          end
          `QPC_OP_COPY_TO_WIP,
          `QPC_OP_SAVE_WIP: begin
            ack_take = 1'b1;
          end
          `QPC_OP_GCOPY_TO_WIP,
          `QPC_OP_GSAVE_WIP: begin
            ack_take = (rx_byte[1:0] == 2'h0);
          end
          default: begin
            ack_take = 1'b0;
          end
        endcase
      end
      qpc_pkg::ds_wdata: begin
        ack_take = 1'b1;
      end
      default: begin
        ack_take = 1'b0;
      end
    endcase
  end

  // Bit framing: bits are taken on rising bus clock edges, the line is driven after falling ones.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q      <= qpc_pkg::ds_idle;
      nxt_q     <= qpc_pkg::ds_idle;
      cnt_q     <= 3'h0;
      sh_q      <= 8'h00;
      drv_q     <= 1'b0;
      sda_oe_q  <= 1'b0;
      op_q      <= 4'h0;
      bank_q    <= 2'h0;
      pot_q     <= 2'h0;
      data_q    <= 8'h00;
      step_up_q <= 1'b0;
    end else if (stop_ev) begin
      st_q     <= qpc_pkg::ds_idle;
      sda_oe_q <= 1'b0;
      drv_q    <= 1'b0;
    end else if (start_ev) begin
      st_q     <= qpc_pkg::ds_devb;
      cnt_q    <= 3'h0;
      sda_oe_q <= 1'b0;
      drv_q    <= 1'b0;
    end else begin
      unique case (st_q)
        qpc_pkg::ds_devb, qpc_pkg::ds_instr, qpc_pkg::ds_wdata: begin
          if (scl_rise) begin
            sh_q  <= rx_byte;
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              st_q  <= ack_take ? qpc_pkg::ds_ack : qpc_pkg::ds_idle;
              nxt_q <= ack_next;
              if (st_q == qpc_pkg::ds_instr) begin
                op_q   <= rx_byte[7:4];
                bank_q <= rx_byte[3:2];
                pot_q  <= rx_byte[1:0];
              end
              if (st_q == qpc_pkg::ds_wdata) begin
                data_q <= rx_byte;
              end
            end
          end
        end
        qpc_pkg::ds_ack: begin
          if (scl_fall && !drv_q) begin
            drv_q    <= 1'b1;
            sda_oe_q <= 1'b1;
          end else if (scl_fall) begin
            drv_q    <= 1'b0;
            st_q     <= nxt_q;
            cnt_q    <= 3'h0;
            sh_q     <= rd_byte;
            sda_oe_q <= (nxt_q == qpc_pkg::ds_rdata) && !rd_byte[7];
          end
        end
        qpc_pkg::ds_rdata: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              st_q <= qpc_pkg::ds_rack;
            end
          end else if (scl_fall) begin
            sh_q     <= {sh_q[6:0], 1'b0};
            sda_oe_q <= !sh_q[6];
          end
        end
        qpc_pkg::ds_rack: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            st_q     <= qpc_pkg::ds_wait;
          end
        end
        qpc_pkg::ds_step: begin
          if (scl_rise) begin
            step_up_q <= sda_s;
            cnt_q     <= 3'h1;
          end else if (scl_fall) begin
            cnt_q <= 3'h0;
          end
        end
        qpc_pkg::ds_idle, qpc_pkg::ds_wait: begin
        end
      endcase
    end
  end

  // The data line is only ever pulled low.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign bus.dev_sda_o  = sda_o_q;
  assign bus.dev_sda_oe = sda_oe_q;

  // ---------------------------------------------------------------------------
  // Command effects and nonvolatile write cycle.
  // ---------------------------------------------------------------------------

  logic                      cmd_ev;
  logic                      step_ev;
  logic                      commit_ev;
  logic                      pend_q;
  logic [BUSY_W-1:0]         busy_cnt_q;

  // A command completes when the final acknowledge is released; a step applies on the fall after its bit.
  assign cmd_ev    = (st_q == qpc_pkg::ds_ack) && scl_fall && drv_q && (nxt_q == qpc_pkg::ds_wait) && !stop_ev;
  assign step_ev   = (st_q == qpc_pkg::ds_step) && scl_fall && cnt_q[0] && !stop_ev && !start_ev;
  assign commit_ev = stop_ev && pend_q;

  // Setting register changes wait for the stop before they are committed.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend_q <= 1'b0;
    end else if (commit_ev || start_ev) begin
      pend_q <= 1'b0;
    end else if (cmd_ev && (op_q == `QPC_OP_WR_SETTING || op_q == `QPC_OP_SAVE_WIP || op_q == `QPC_OP_GSAVE_WIP)) begin
      pend_q <= 1'b1;
    end
  end

  // Write cycle timer; the device byte goes unanswered until it expires.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_q     <= 1'b0;
      busy_cnt_q <= '0;
    end else if (commit_ev) begin
      busy_q     <= 1'b1;
      busy_cnt_q <= BUSY_W'(NV_WRITE_CYCLES - 1);
    end else if (busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - BUSY_W'(1);
    end else begin
      busy_q <= 1'b0;
    end
  end

  assign o_nv_busy = busy_q;

  // Per potentiometer: wiper position register and four stored setting registers.
  for (genvar p = 0; p < 4; p++) begin : g_pot
    logic [7:0] wip_q;
    logic [7:0] nv_q [4];
    logic       sel;

    assign sel                 = (pot_q == 2'(p));
    assign nv_sel_w[p]         = nv_q[bank_q];
    assign o_wiper_pos[p*8 +: 8] = wip_q;

    // Wiper updates from a direct write, a copy or a step.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        wip_q <= `QPC_WIPER_RESET;
      end else if (cmd_ev && sel && op_q == `QPC_OP_WR_WIPER) begin
        wip_q <= data_q;
      end else if (cmd_ev && ((sel && op_q == `QPC_OP_COPY_TO_WIP) || op_q == `QPC_OP_GCOPY_TO_WIP)) begin
        wip_q <= nv_q[bank_q];
      end else if (step_ev && sel && step_up_q && wip_q != `QPC_WIPER_MAX) begin
        wip_q <= wip_q + 8'h01;
      end else if (step_ev && sel && !step_up_q && wip_q != `QPC_WIPER_MIN) begin
        wip_q <= wip_q - 8'h01;
      end
    end

    // Setting registers change only when a pending write commits at the stop.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        for (int b = 0; b < 4; b++) begin
          nv_q[b] <= `QPC_SETTING_RESET;
        end
      end else if (commit_ev && sel && op_q == `QPC_OP_WR_SETTING) begin
        nv_q[bank_q] <= data_q;
      end else if (commit_ev && ((sel && op_q == `QPC_OP_SAVE_WIP) || op_q == `QPC_OP_GSAVE_WIP)) begin
        nv_q[bank_q] <= wip_q;
      end
    end
  end

endmodule

// >>> src/qpc_host.sv
`timescale 1ns/1ps
`include "qpc_consts.svh"

module qpc_host (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Two-wire bus.
  qpc_bus_if.host          bus,
  // Command request.
  input  wire logic        i_cmd_valid,
  input  wire logic [3:0]  i_cmd_op,
  input  wire logic [3:0]  i_cmd_addr,
  input  wire logic [1:0]  i_cmd_bank,
  input  wire logic [1:0]  i_cmd_pot,
  input  wire logic [7:0]  i_cmd_data,
  input  wire logic [7:0]  i_cmd_steps,
  input  wire logic        i_cmd_step_up,
  // Command answer.
  output logic             o_cmd_ready,
  output logic             o_done,
  output logic             o_nack,
  output logic      [7:0]  o_rd_data
);

  // ---------------------------------------------------------------------------
  // Data line synchroniser.
  // ---------------------------------------------------------------------------

  logic [1:0]                sda_sy_q;
  logic                      sda_s;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_sy_q <= 2'h3;
    end else begin
      sda_sy_q <= {sda_sy_q[0], bus.sda};
    end
  end

  assign sda_s = sda_sy_q[1];

  // ---------------------------------------------------------------------------
  // Frame sequencer.
  // ---------------------------------------------------------------------------

  qpc_pkg::qpc_host_state_t  st_q;
  logic [3:0]                ph_q;
  logic [1:0]                seg_q;
  logic [3:0]                bit_q;
  logic [7:0]                tx_q;
  logic [7:0]                rx_q;
  logic [7:0]                ins_q;
  logic [7:0]                data_q;
  logic [7:0]                steps_q;
  logic [3:0]                op_q;
  logic                      up_q;
  logic                      has2_q;
  logic                      nack_q;
  logic                      scl_q;
  logic                      sda_oe_q;
  logic                      sda_o_q;
  logic                      ready_q;
  logic                      done_q;
  logic                      nack_out_q;
  logic [7:0]                rd_out_q;
  logic                      step_seg;
  logic                      rd_seg;
  logic                      rx_slot;
  logic [7:0]                ins_byte;

  assign step_seg = (seg_q == 2'h2) && (op_q == `QPC_OP_STEP);
  assign rd_seg   = (seg_q == 2'h2) && (op_q == `QPC_OP_RD_SETTING);
  assign rx_slot  = rd_seg ? (bit_q != `QPC_ACK_BIT_IDX) : ((bit_q == `QPC_ACK_BIT_IDX) && !step_seg);
  // Fields that must be zero for an instruction are forced here.
  assign ins_byte = {i_cmd_op,
                     (i_cmd_op == `QPC_OP_WR_WIPER || i_cmd_op == `QPC_OP_STEP) ? 2'h0 : i_cmd_bank,
                     (i_cmd_op == `QPC_OP_GCOPY_TO_WIP || i_cmd_op == `QPC_OP_GSAVE_WIP) ? 2'h0 : i_cmd_pot};

  // Each bit occupies one 16-cycle slot: clock low, data set, clock high, sample.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q     <= qpc_pkg::hs_idle;
      ph_q     <= 4'h0;
      seg_q    <= 2'h0;
      bit_q    <= 4'h0;
      tx_q     <= 8'h00;
      rx_q     <= 8'h00;
      ins_q    <= 8'h00;
      data_q   <= 8'h00;
      steps_q  <= 8'h00;
      op_q     <= 4'h0;
      up_q     <= 1'b0;
      has2_q   <= 1'b0;
      nack_q   <= 1'b0;
      scl_q    <= 1'b1;
      sda_oe_q <= 1'b0;
      ready_q  <= 1'b1;
      done_q   <= 1'b0;
      nack_out_q <= 1'b0;
      rd_out_q <= 8'h00;
    end else begin
      done_q <= 1'b0;
      ph_q   <= (st_q == qpc_pkg::hs_idle) ? 4'h0 : ph_q + 4'h1;
      unique case (st_q)
        qpc_pkg::hs_idle: begin
          scl_q    <= 1'b1;
          sda_oe_q <= 1'b0;
          if (i_cmd_valid && ready_q) begin
            ready_q <= 1'b0;
            st_q    <= qpc_pkg::hs_start;
            tx_q    <= {`QPC_DEV_TYPE, i_cmd_addr};
            ins_q   <= ins_byte;
            data_q  <= i_cmd_data;
            steps_q <= i_cmd_steps;
            up_q    <= i_cmd_step_up;
            op_q    <= i_cmd_op;
            has2_q  <= (i_cmd_op == `QPC_OP_WR_WIPER) || (i_cmd_op == `QPC_OP_WR_SETTING)
                       || (i_cmd_op == `QPC_OP_RD_SETTING) || (i_cmd_op == `QPC_OP_STEP && i_cmd_steps != 8'h00);
            nack_q  <= 1'b0;
            rx_q    <= 8'h00;
          end
        end
        qpc_pkg::hs_start: begin
          if (ph_q == `QPC_PH_SCL_HIGH) begin
            sda_oe_q <= 1'b1;
          end
          if (ph_q == `QPC_PH_LAST) begin
            st_q  <= qpc_pkg::hs_bit;
            seg_q <= 2'h0;
            bit_q <= 4'h0;
          end
        end
        qpc_pkg::hs_bit: begin
          if (ph_q == `QPC_PH_SCL_LOW) begin
            scl_q <= 1'b0;
          end
          if (ph_q == `QPC_PH_SDA_SET) begin
            sda_oe_q <= rx_slot ? 1'b0 : step_seg ? !up_q : (bit_q == `QPC_ACK_BIT_IDX) ? 1'b1 : !tx_q[7];
          end
          if (ph_q == `QPC_PH_SCL_HIGH) begin
            scl_q <= 1'b1;
          end
          if (ph_q == `QPC_PH_SAMPLE && rx_slot && bit_q == `QPC_ACK_BIT_IDX) begin
            nack_q <= sda_s;
          end else if (ph_q == `QPC_PH_SAMPLE && rx_slot) begin
            rx_q <= {rx_q[6:0], sda_s};
          end
          if (ph_q == `QPC_PH_LAST) begin
            if (step_seg) begin
              steps_q <= steps_q - 8'h01;
              if (steps_q == 8'h01) begin
                st_q <= qpc_pkg::hs_stop;
              end
            end else if (bit_q != `QPC_ACK_BIT_IDX) begin
              bit_q <= bit_q + 4'h1;
              tx_q  <= {tx_q[6:0], 1'b0};
            end else begin
              bit_q <= 4'h0;
              if (nack_q) begin
                st_q <= qpc_pkg::hs_stop;
              end else if (seg_q == 2'h0) begin
                seg_q <= 2'h1;
                tx_q  <= ins_q;
              end else if (seg_q == 2'h1 && has2_q) begin
                seg_q <= 2'h2;
                tx_q  <= data_q;
              end else begin
                st_q <= qpc_pkg::hs_stop;
              end
            end
          end
        end
        qpc_pkg::hs_stop: begin
          if (ph_q == `QPC_PH_SCL_LOW) begin
            scl_q <= 1'b0;
          end
          if (ph_q == `QPC_PH_SDA_SET) begin
            sda_oe_q <= 1'b1;
          end
          if (ph_q == `QPC_PH_SCL_HIGH) begin
            scl_q <= 1'b1;
          end
          if (ph_q == `QPC_PH_STOP_REL) begin
            sda_oe_q <= 1'b0;
          end
          if (ph_q == `QPC_PH_LAST) begin
            st_q       <= qpc_pkg::hs_idle;
            ready_q    <= 1'b1;
            done_q     <= 1'b1;
            nack_out_q <= nack_q;
            rd_out_q   <= rx_q;
          end
        end
      endcase
    end
  end

  // The host only ever pulls the data line low.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign bus.scl         = scl_q;
  assign bus.host_sda_o  = sda_o_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign o_cmd_ready     = ready_q;
  assign o_done          = done_q;
  assign o_nack          = nack_out_q;
  assign o_rd_data       = rd_out_q;

endmodule

// >>> verification/qpc_bus_sva.sv
`timescale 1ns/1ps
module qpc_bus_sva (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Bus wires.
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic [7:0] hold_q;

  // Counts how long the device keeps the line low.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_q <= 8'h00;
    end else begin
      hold_q <= dev_sda_oe ? hold_q + 8'h01 : 8'h00;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // The data wire is open drain and every bus clock phase lasts at least eight cycles.
  chk_dev_od: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drove high");
  chk_host_od: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drove high");
  chk_scl_high: assert property ($rose(scl) |-> scl[*8])
    else $error("short clock high");
  chk_scl_low: assert property ($fell(scl) |-> !scl[*8])
    else $error("short clock low");
  chk_dev_grab: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device grabbed line late");
  chk_dev_free: assert property ($fell(dev_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device freed line late");
  chk_dev_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device moved in clock high");
  chk_dev_hold: assert property (hold_q < 8'ha0)
    else $error("device held line too long");
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  localparam int NV = 200;
  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_cmd_valid = 1'b0;
  logic        i_cmd_step_up = 1'b0;
  logic [3:0]  i_cmd_op = 4'h0;
  logic [3:0]  i_cmd_addr = 4'h0;
  logic [1:0]  i_cmd_bank = 2'h0;
  logic [1:0]  i_cmd_pot = 2'h0;
  logic [7:0]  i_cmd_data = 8'h00;
  logic        o_cmd_ready;
  logic        o_done;
  logic        o_nack;
  logic        o_nv_busy;
  logic        e_nack;
  logic [7:0]  o_rd_data;
  logic [31:0] o_wiper_pos;
  logic [31:0] e_val;
  int          fails = 0;
  int          tests_run = 0;
  // Rows: opcode, address, bank, pot, data or steps, up, nack, wipers or read byte.
  logic [53:0] rows [18] = '{
    {4'ha,4'h5,2'h0,2'h1,8'h5a,1'h0,1'h0,32'h0000_5a00},
    {4'hc,4'h5,2'h2,2'h0,8'hc3,1'h0,1'h0,32'h0000_5a00},
    {4'hb,4'h5,2'h2,2'h0,8'h00,1'h0,1'h1,32'h0000_5a00},
    {4'hb,4'h5,2'h2,2'h0,8'h00,1'h0,1'h0,32'h0000_00c3},
    {4'hd,4'h5,2'h2,2'h0,8'h00,1'h0,1'h0,32'h0000_5ac3},
    {4'h2,4'h5,2'h0,2'h0,8'h05,1'h0,1'h0,32'h0000_5abe},
    {4'ha,4'h5,2'h0,2'h3,8'hfe,1'h0,1'h0,32'hfe00_5abe},
    {4'h2,4'h5,2'h0,2'h3,8'h03,1'h1,1'h0,32'hff00_5abe},
    {4'he,4'h5,2'h3,2'h3,8'h00,1'h0,1'h0,32'hff00_5abe},
    {4'hb,4'h5,2'h3,2'h3,8'h00,1'h0,1'h1,32'hff00_5abe},
    {4'h8,4'h5,2'h1,2'h0,8'h00,1'h0,1'h0,32'hff00_5abe},
    {4'h1,4'h5,2'h3,2'h0,8'h00,1'h0,1'h1,32'hff00_5abe},
    {4'h1,4'h5,2'h3,2'h0,8'h00,1'h0,1'h0,32'hff00_0000},
    {4'h9,4'h5,2'h0,2'h0,8'h00,1'h0,1'h1,32'hff00_0000},
    {4'ha,4'h6,2'h0,2'h0,8'h11,1'h0,1'h1,32'hff00_0000},
    {4'h1,4'h5,2'h1,2'h0,8'h00,1'h0,1'h0,32'hff00_5abe},
    {4'hb,4'h5,2'h1,2'h1,8'h00,1'h0,1'h0,32'h0000_005a},
    {4'hc,4'h5,2'h0,2'h2,8'h77,1'h0,1'h0,32'hff00_5abe}};

  // Bench clock of 4 ns.
  always #2 i_clk = ~i_clk;

  // The two ends face each other; the checker watches the wires.
  qpc_bus_if qpc_bus_if_i ();
  qpc_device #(.NV_WRITE_CYCLES(NV)) qpc_device_i (.i_clk, .i_rst_b, .bus(qpc_bus_if_i),
    .i_addr_strap(4'h5), .o_wiper_pos, .o_nv_busy);
  qpc_host qpc_host_i (.i_clk, .i_rst_b, .bus(qpc_bus_if_i), .i_cmd_valid, .i_cmd_op, .i_cmd_addr,
    .i_cmd_bank, .i_cmd_pot, .i_cmd_data, .i_cmd_steps(i_cmd_data), .i_cmd_step_up, .o_cmd_ready,
    .o_done, .o_nack, .o_rd_data);
  qpc_bus_sva qpc_bus_sva_i (.i_clk, .i_rst_b, .scl(qpc_bus_if_i.scl), .sda(qpc_bus_if_i.sda),
    .host_sda_o(qpc_bus_if_i.host_sda_o), .host_sda_oe(qpc_bus_if_i.host_sda_oe),
    .dev_sda_o(qpc_bus_if_i.dev_sda_o), .dev_sda_oe(qpc_bus_if_i.dev_sda_oe));

  // Compares one flag or one value and counts the outcome.
  task automatic chk_bit(string nm, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_vec(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Runs the rows, then the write cycle length and a reset in mid-run.
  initial begin
    int n;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    for (int r = 0; r < 18; r++) begin
      @(posedge i_clk);
      {i_cmd_op, i_cmd_addr, i_cmd_bank, i_cmd_pot, i_cmd_data, i_cmd_step_up, e_nack, e_val} <= rows[r];
      i_cmd_valid <= 1'b1;
      @(posedge i_clk);
      i_cmd_valid <= 1'b0;
      n = 0;
      while (o_done !== 1'b1 && n < 2000) begin
        @(negedge i_clk);
        n++;
      end
      chk_bit("done", 1'b1, o_done);
      chk_bit("nack", e_nack, o_nack);
      if (i_cmd_op == 4'hb && !e_nack) begin
        chk_vec("read", e_val, {24'h00_0000, o_rd_data});
      end else begin
        chk_vec("wiper", e_val, o_wiper_pos);
      end
      $display("row %0d done", r);
    end
    n = 0;
    while (o_nv_busy !== 1'b1 && n < 16) begin
      @(negedge i_clk);
      n++;
    end
    n = 0;
    while (o_nv_busy === 1'b1 && n < 300) begin
      @(negedge i_clk);
      n++;
    end
    chk_vec("busy cycles", NV, n);
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    @(negedge i_clk);
    chk_vec("reset wiper", 32'h0000_0000, o_wiper_pos);
    chk_bit("reset ready", 1'b1, o_cmd_ready);
    $display("reset test done");
    // After release, a setting read must find the stored byte back at its reset value.
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    {i_cmd_op, i_cmd_bank, i_cmd_pot, i_cmd_valid} <= {4'hb, 2'h0, 2'h2, 1'b1};
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    wait (o_done === 1'b1);
    @(negedge i_clk);
    chk_bit("recover nack", 1'b0, o_nack);
    chk_vec("recover read", 32'h0000_0000, {24'h00_0000, o_rd_data});
    $display("recovery test done");
    report_and_stop();
  end

  // Cuts a hung run short.
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
